/* File: common/lscd_params.svh */
`ifndef LSCD_PARAMS_SVH
`define LSCD_PARAMS_SVH

// register byte offsets on the apb bus
`define LSCD_OFS_FPST 12'h000
`define LSCD_OFS_EXST 12'h004
`define LSCD_OFS_CTRL 12'h008

// fp_status_reg flag positions
`define LSCD_FL_IO 0
`define LSCD_FL_UF 1
`define LSCD_FL_OF 2
`define LSCD_FL_DO 3

// control register fields and reset values
`define LSCD_CTRL_EXCEN 0
`define LSCD_CTRL_RST 32'h0000_0001
`define LSCD_FPST_RST 4'h0
`define LSCD_EXST_RST 5'h00

// exception cause code for floating-point exceptions
`define LSCD_CAUSE_FP 5'h06

// default quiet nan written when an invalid or denormal-operand result is not trapped
`define LSCD_QNAN 64'h7FF8_0000_0000_0000
`define LSCD_EXP_ONES 11'h7FF

// completion latencies in cycles
`define LSCD_LAT_SH 3'h1
`define LSCD_LAT_SH_AREA1 3'h2
`define LSCD_LAT_CMP 3'h1
`define LSCD_LAT_FP_AREA0 3'h4
`define LSCD_LAT_FP_AREA1 3'h6
`define LSCD_LAT_FP_AREA2 3'h1

`endif

/* File: common/lscd_pkg.sv */
package lscd_pkg;

   // operation class selected by the decoder
   typedef enum logic [1:0] {
      op_shift,
      op_cmp,
      op_dadd,
      op_drsub
   } lscd_op_t;

   // decoded instruction fields
   typedef struct packed {
      lscd_op_t op;
      logic side;
      logic typ;
      logic ext;
      logic ins;
      logic cmp_uns;
      logic [5:0] imm_w;
      logic [5:0] imm_s;
   } lscd_issue_t;

   // completed result with its side effects
   typedef struct packed {
      logic [63:0] data;
      logic we;
      logic exc;
      logic cfg_err;
      logic [3:0] fl;
   } lscd_res_t;

endpackage

/* File: rtl/lscd_dadd.sv */
// double-precision adder, round to nearest even, normal operands only
module lscd_dadd
   import lscd_pkg::*;
(
   input wire logic [63:0] x,
   input wire logic [63:0] y,
   output logic [63:0] sum,
   output logic ovf,
   output logic unf
);
   `include "lscd_params.svh"

   logic [63:0] big, sml;
   logic [55:0] mb, ms, al, nrm;
   logic [11:0] dif;
   logic [56:0] raw;
   logic [53:0] rnd;
   logic [5:0] lz;
   logic signed [12:0] ex;
   logic sub, stk, rup;

   // order by magnitude and align the smaller operand with sticky
   always_comb begin
      big = (x[62:0] >= y[62:0]) ? x : y;
      sml = (x[62:0] >= y[62:0]) ? y : x;
      sub = big[63] ^ sml[63];
      mb = {(big[62:52] != 11'h000), big[51:0], 3'b000};
      ms = {(sml[62:52] != 11'h000), sml[51:0], 3'b000};
      dif = {1'b0, big[62:52]} - {1'b0, sml[62:52]};
      if (dif > 12'h037) begin
         al = '0;
         stk = |ms;
      end else begin
         al = ms >> dif;
         stk = |(ms & ~({56{1'b1}} << dif));
      end
      al[0] = al[0] | stk;
      raw = sub ? ({1'b0, mb} - {1'b0, al}) : ({1'b0, mb} + {1'b0, al});
   end

   // normalise, round and pack
   always_comb begin
      lz = '0;
      for (int i = 0; i < 56; i++) begin
         if (raw[i]) lz = 6'(55 - i);
      end
      if (raw[56]) begin
         nrm = {raw[56:2], raw[1] | raw[0]};
         ex = $signed({2'b00, big[62:52]}) + 13'sh0001;
      end else begin
         nrm = raw[55:0] << lz;
         ex = $signed({2'b00, big[62:52]}) - $signed({7'h00, lz});
      end
      rup = nrm[2] & (nrm[1] | nrm[0] | nrm[3]);
      rnd = {1'b0, nrm[55:3]} + {53'h0, rup};
      if (rnd[53]) ex = ex + 13'sh0001;
      ovf = (big[62:52] != `LSCD_EXP_ONES) && (ex >= 13'sh07FF);
      unf = (raw != '0) && (ex <= 13'sh0000);
      if (big[62:52] == `LSCD_EXP_ONES) begin
         sum = big; // infinity passes through
         ovf = 1'b0;
         unf = 1'b0;
      end else if (raw == '0) begin
         sum = {x[63] & y[63], 63'h0}; // exact cancellation gives +0
      end else begin
         sum = {big[63], ex[10:0], rnd[53] ? rnd[52:1] : rnd[51:0]};
      end
   end
endmodule // lscd_dadd

/* File: rtl/lscd_unit.sv */
// What this block does
// - plain immediate long shifts move source by immediate amount into destination
// - side bit one shifts left, zero shifts right
// - type bit on right shift fills with sign; zero amount copies source
// - extract ignores side/type, shifts right, keeps low width bits, clears rest
// - insert mask spans shift..width field; shifted source merged into old destination
// - insert ignores side/type; priority extract, insert, left, arithmetic right
// - shift forms ignore any immediate prefix; fields come from own encoding
// - shift, extract, insert exist only when barrel option equals one
// - shift forms take one cycle at area levels 0 and 2, two at 1
// - long compare writes second operand minus first as b plus not a plus one
// - compare result top bit replaced by first operand greater than second
// - unsigned bit clear compares signed, set compares unsigned
// - double add writes ieee double sum when no operand is exceptional
// - reverse subtract writes second minus first in double precision
// - denormal operand sets denormal flag and cause code 00110
// - signalling nan or invalid infinity pair sets invalid flag and cause 00110
// - denormal result gives signed zero, underflow flag, cause 00110
// - overflowing result gives signed infinity, overflow flag, cause 00110
// - generated exception leaves destination unchanged and updates cause field
// - double add and subtract take 4, 6 or 1 cycles by area level
// - double operations exist only when fpu level is above zero
//
// The placing of the registers and the APB register port were decided locally.
module lscd_unit
   import lscd_pkg::*;
#(
   parameter int AREA_OPT = 0,
   parameter int USE_BARREL = 1,
   parameter int FPU_LEVEL = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic issue_valid,
   output logic issue_ready,
   input wire lscd_issue_t issue,
   input wire logic [63:0] opa,
   input wire logic [63:0] opb,
   input wire logic [63:0] opd,
   output logic done,
   output logic rd_we,
   output logic [63:0] rd_data,
   output logic fp_exc,
   output logic [4:0] exception_cause_code,
   output logic cfg_err
);
   `include "lscd_params.svh"

   localparam logic [2:0] LAT_SH = (AREA_OPT == 1) ? `LSCD_LAT_SH_AREA1 : `LSCD_LAT_SH;
   localparam logic [2:0] LAT_FP = (AREA_OPT == 0) ? `LSCD_LAT_FP_AREA0 :
                                   (AREA_OPT == 1) ? `LSCD_LAT_FP_AREA1 : `LSCD_LAT_FP_AREA2;

   logic [2:0] cnt_ff, nxt_cnt;
   lscd_res_t res_ff, nxt_res;
   logic [3:0] fp_status_reg_ff;
   logic [4:0] exception_status_reg_ff;
   logic [31:0] ctrl_ff;
   logic [31:0] prdata_ff;
   logic accept, acc, wr;
   logic [63:0] xa, sum, mask;
   logic ovf, unf;

   // operand classification shared by both fp forms
   function automatic logic f_dnz(input logic [63:0] v);
      return (v[62:52] == 11'h000) && (v[51:0] != 52'h0);
   endfunction

   function automatic logic f_inf(input logic [63:0] v);
      return (v[62:52] == `LSCD_EXP_ONES) && (v[51:0] == 52'h0);
   endfunction

   function automatic logic f_snan(input logic [63:0] v);
      return (v[62:52] == `LSCD_EXP_ONES) && !v[51] && (v[50:0] != 51'h0);
   endfunction

   function automatic logic f_qnan(input logic [63:0] v);
      return (v[62:52] == `LSCD_EXP_ONES) && v[51];
   endfunction

   // latency of an accepted operation
   function automatic logic [2:0] f_lat(input lscd_op_t op);
      case (op)
         op_shift: return LAT_SH;
         op_cmp: return `LSCD_LAT_CMP;
         op_dadd, op_drsub: return (FPU_LEVEL > 0) ? LAT_FP : 3'h1;
         default: return 3'h1;
      endcase
   endfunction

   // one operation at a time; a new one is taken once the last has completed
   assign issue_ready = (cnt_ff == 3'h0);
   assign accept = issue_valid && issue_ready;

   // reverse subtract is b plus negated a
   assign xa = (issue.op == op_drsub) ? {~opa[63], opa[62:0]} : opa;

   // insert mask covers bit positions shift .. width field
   assign mask = ({64{1'b1}} << issue.imm_s) & ({64{1'b1}} >> (6'h3F - issue.imm_w));

   lscd_dadd u_dadd (
      .x(xa),
      .y(opb),
      .sum(sum),
      .ovf(ovf),
      .unf(unf)
   );

   // result of the operation being issued
   always_comb begin
      nxt_res = '0;
      nxt_res.we = 1'b1;
      case (issue.op)
         op_shift: begin
            // fields come only from this encoding, no prefix input exists
            if (USE_BARREL != 1) begin
               nxt_res.we = 1'b0;
               nxt_res.cfg_err = 1'b1;
            end else if (issue.ext) begin
               nxt_res.data = (opa >> issue.imm_s) & ~({64{1'b1}} << issue.imm_w);
            end else if (issue.ins) begin
               nxt_res.data = ((opa << issue.imm_s) & mask) | (opd & ~mask);
            end else if (issue.side) begin
               nxt_res.data = opa << issue.imm_s;
            end else if (issue.typ) begin
               nxt_res.data = $unsigned($signed(opa) >>> issue.imm_s);
            end else begin
               nxt_res.data = opa >> issue.imm_s;
            end
         end
         op_cmp: begin
            nxt_res.data = opb + ~opa + 64'h0000_0000_0000_0001;
            if (issue.cmp_uns) begin
               nxt_res.data[63] = (opa > opb);
            end else begin
               nxt_res.data[63] = ($signed(opa) > $signed(opb));
            end
         end
         default: begin
            if (FPU_LEVEL <= 0) begin
               nxt_res.we = 1'b0;
               nxt_res.cfg_err = 1'b1;
            end else begin
               nxt_res.data = sum;
               if (f_dnz(opa) || f_dnz(opb)) begin
                  nxt_res.fl[`LSCD_FL_DO] = 1'b1;
               end else if (f_snan(opa) || f_snan(opb) ||
                            (f_inf(xa) && f_inf(opb) && (xa[63] != opb[63]))) begin
                  nxt_res.fl[`LSCD_FL_IO] = 1'b1;
               end else if (f_qnan(opa)) begin
                  nxt_res.data = opa;
               end else if (f_qnan(opb)) begin
                  nxt_res.data = opb;
               end else if (unf) begin
                  nxt_res.data = {sum[63], 63'h0};
                  nxt_res.fl[`LSCD_FL_UF] = 1'b1;
               end else if (ovf) begin
                  nxt_res.data = {sum[63], `LSCD_EXP_ONES, 52'h0};
                  nxt_res.fl[`LSCD_FL_OF] = 1'b1;
               end
               // trapping keeps the destination; untrapped flags still write a value
               if (nxt_res.fl != 4'h0) begin
                  nxt_res.exc = ctrl_ff[`LSCD_CTRL_EXCEN];
                  nxt_res.we = !nxt_res.exc;
                  if (nxt_res.fl[`LSCD_FL_DO] || nxt_res.fl[`LSCD_FL_IO]) begin
                     nxt_res.data = `LSCD_QNAN;
                  end
               end
            end
         end
      endcase
   end

   // completion countdown
   always_comb begin
      nxt_cnt = cnt_ff;
      if (accept) begin
         nxt_cnt = f_lat(issue.op);
      end else if (cnt_ff != 3'h0) begin
         nxt_cnt = cnt_ff - 3'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_ff <= 3'h0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   // result is captured at issue and held until completion
   always_ff @(posedge clk) begin
      if (rst) begin
         res_ff <= '0;
      end else if (accept) begin
         res_ff <= nxt_res;
      end
   end

   // completion outputs: done from the countdown, the rest taken from the held result
   assign done = (cnt_ff == 3'h1);
   assign rd_we = done && res_ff.we;
   assign rd_data = res_ff.data;
   assign fp_exc = done && res_ff.exc;
   assign cfg_err = done && res_ff.cfg_err;
   assign exception_cause_code = res_ff.exc ? `LSCD_CAUSE_FP : 5'h00;

   // apb access phase; every transfer completes without wait states
   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign pready = 1'b1;
   assign pslverr = acc && (paddr != `LSCD_OFS_FPST) && (paddr != `LSCD_OFS_EXST) &&
                    (paddr != `LSCD_OFS_CTRL);
   assign prdata = prdata_ff;

   // fp status flags: sticky, write one to clear, a new flag wins over the clear
   always_ff @(posedge clk) begin
      if (rst) begin
         fp_status_reg_ff <= `LSCD_FPST_RST;
      end else begin
         fp_status_reg_ff <= (fp_status_reg_ff &
                              ~((wr && paddr == `LSCD_OFS_FPST) ? pwdata[3:0] : 4'h0)) |
                             (done ? res_ff.fl : 4'h0);
      end
   end

   // exception cause: loaded on a trapped exception, any write clears it
   always_ff @(posedge clk) begin
      if (rst) begin
         exception_status_reg_ff <= `LSCD_EXST_RST;
      end else if (done && res_ff.exc) begin
         exception_status_reg_ff <= `LSCD_CAUSE_FP;
      end else if (wr && paddr == `LSCD_OFS_EXST) begin
         exception_status_reg_ff <= `LSCD_EXST_RST;
      end
   end

   // control: bit 0 enables trapping of fp exceptions
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_ff <= `LSCD_CTRL_RST;
      end else if (wr && paddr == `LSCD_OFS_CTRL) begin
         ctrl_ff <= {31'h0, pwdata[`LSCD_CTRL_EXCEN]};
      end
   end

   // read data is prepared in the setup phase and held through access
   always_ff @(posedge clk) begin
      if (rst) begin
         prdata_ff <= 32'h0;
      end else if (psel && !penable) begin
         case (paddr)
            `LSCD_OFS_FPST: prdata_ff <= {28'h0, fp_status_reg_ff};
            `LSCD_OFS_EXST: prdata_ff <= {27'h0, exception_status_reg_ff};
            `LSCD_OFS_CTRL: prdata_ff <= ctrl_ff;
            default: prdata_ff <= 32'h0;
         endcase
      end
   end

   // checking helpers: the accepted request is kept until completion
   // done is sampled high exactly latency edges after the accepting edge
   localparam int D_SH = int'(LAT_SH);
   localparam int D_FP = int'(LAT_FP);
   lscd_issue_t chk_ff;
   logic [63:0] chk_a_ff, chk_b_ff, chk_d_ff, chk_m;

   always_ff @(posedge clk) begin
      if (accept) begin
         chk_ff <= issue;
         chk_a_ff <= opa;
         chk_b_ff <= opb;
         chk_d_ff <= opd;
      end
   end

   assign chk_m = ({64{1'b1}} << chk_ff.imm_s) & ({64{1'b1}} >> (6'h3F - chk_ff.imm_w));

   property p_shl;
      @(posedge clk) disable iff (rst)
      done && chk_ff.op == op_shift && !chk_ff.ext && !chk_ff.ins && chk_ff.side
         |-> rd_we && rd_data == (chk_a_ff << chk_ff.imm_s);
   endproperty
   a_shl: assert property (p_shl) else $error("left shift result wrong");

   property p_sra;
      @(posedge clk) disable iff (rst)
      done && chk_ff.op == op_shift && !chk_ff.ext && !chk_ff.ins && !chk_ff.side &&
         chk_ff.typ && chk_ff.imm_s != 6'h00
         |-> rd_data == ((chk_a_ff >> chk_ff.imm_s) |
                         ({64{chk_a_ff[63]}} & ~({64{1'b1}} >> chk_ff.imm_s)));
   endproperty
   a_sra: assert property (p_sra) else $error("arithmetic right shift wrong");

   property p_ext;
      @(posedge clk) disable iff (rst)
      done && chk_ff.op == op_shift && chk_ff.ext && chk_ff.imm_w != 6'h00
         |-> (rd_data >> chk_ff.imm_w) == 64'h0 &&
             rd_data[0] == chk_a_ff[chk_ff.imm_s];
   endproperty
   a_ext: assert property (p_ext) else $error("extract result wrong");

   property p_ins;
      @(posedge clk) disable iff (rst)
      done && chk_ff.op == op_shift && !chk_ff.ext && chk_ff.ins
         |-> (rd_data & ~chk_m) == (chk_d_ff & ~chk_m);
   endproperty
   a_ins: assert property (p_ins) else $error("insert touched bits outside mask");

   property p_cmp;
      @(posedge clk) disable iff (rst)
      done && chk_ff.op == op_cmp
         |-> rd_data[62:0] == 63'(chk_b_ff - chk_a_ff) &&
             rd_data[63] == (chk_ff.cmp_uns ? (chk_b_ff < chk_a_ff) :
                             ($signed(chk_b_ff) < $signed(chk_a_ff)));
   endproperty
   a_cmp: assert property (p_cmp) else $error("long compare result wrong");

   property p_sh_lat;
      @(posedge clk) disable iff (rst)
      accept && issue.op == op_shift |-> ##D_SH done;
   endproperty
   a_sh_lat: assert property (p_sh_lat) else $error("shift latency wrong");

   property p_fp_lat;
      @(posedge clk) disable iff (rst)
      accept && FPU_LEVEL > 0 && (issue.op == op_dadd || issue.op == op_drsub)
         |-> !done ##D_FP done;
   endproperty
   a_fp_lat: assert property (p_fp_lat) else $error("fp latency wrong");

   property p_exc;
      @(posedge clk) disable iff (rst)
      fp_exc |-> !rd_we && exception_cause_code == 5'h06 ##1
         exception_status_reg_ff == 5'h06;
   endproperty
   a_exc: assert property (p_exc) else $error("trapped fp exception mishandled");

   property p_ovf;
      @(posedge clk) disable iff (rst)
      done && res_ff.fl[`LSCD_FL_OF] && rd_we |-> rd_data[62:0] == {`LSCD_EXP_ONES, 52'h0}
         ##1 fp_status_reg_ff[`LSCD_FL_OF];
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow result wrong");

   c_fp_trap: cover property (@(posedge clk) disable iff (rst) fp_exc);
   c_insert: cover property (@(posedge clk) disable iff (rst) done && chk_ff.ins && rd_we);
   c_cmp_uns: cover property (@(posedge clk) disable iff (rst) done && chk_ff.cmp_uns);
   c_b2b: cover property (@(posedge clk) disable iff (rst) done ##1 accept);
endmodule // lscd_unit

/* File: sim/tb_top.sv */
`include "lscd_params.svh"

module tb_top
   import lscd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic issue_valid, issue_ready, done, rd_we, fp_exc, cfg_err, errv, got_we, got_exc;
   lscd_issue_t issue, t;
   logic [63:0] opa, opb, opd, rd_data, got_data, a, b, d, e;
   logic [4:0] exception_cause_code, got_cause;
   logic [5:0] s, w;
   int miscompares = 0, total_checks = 0, seed = 18, cycles = 0, got_lat, i, k, m;
   // trapping cases: operation, operands, flag bit, untrapped result
   lscd_op_t xo [6] = '{op_dadd, op_dadd, op_dadd, op_drsub, op_dadd, op_drsub};
   logic [63:0] xa [6] = '{64'h0000_0000_0000_0001, 64'h7FF0_0000_0000_0001,
      64'h7FF0_0000_0000_0000, 64'h7FF0_0000_0000_0000, 64'hFFEF_FFFF_FFFF_FFFF,
      64'h0010_0000_0000_0000};
   logic [63:0] xb [6] = '{64'h3FF0_0000_0000_0000, 64'h3FF0_0000_0000_0000,
      64'hFFF0_0000_0000_0000, 64'h7FF0_0000_0000_0000, 64'hFFEF_FFFF_FFFF_FFFF,
      64'h0010_0000_0000_0001};
   int xf [6] = '{`LSCD_FL_DO, `LSCD_FL_IO, `LSCD_FL_IO, `LSCD_FL_IO, `LSCD_FL_OF, `LSCD_FL_UF};
   logic [63:0] xr [6] = '{`LSCD_QNAN, `LSCD_QNAN, `LSCD_QNAN, `LSCD_QNAN,
      64'hFFF0_0000_0000_0000, 64'h0000_0000_0000_0000};

   lscd_unit lscd_unit_inst (
      .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .issue_valid(issue_valid), .issue_ready(issue_ready),
      .issue(issue), .opa(opa), .opb(opb), .opd(opd), .done(done), .rd_we(rd_we),
      .rd_data(rd_data), .fp_exc(fp_exc), .exception_cause_code(exception_cause_code),
      .cfg_err(cfg_err)
   );

   // core clock, 20 ns period
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end

   // hang guard
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 10000) begin
         miscompares = miscompares + 1;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      if (miscompares == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one apb transfer: setup, then access until pready
   task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'h1;
      do begin
         @(posedge clk);
      end while (pready !== 1'h1);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   // issue one operation and wait for its completion pulse
   task automatic run_op(input lscd_issue_t iss, input logic [63:0] x, input logic [63:0] y,
                         input logic [63:0] z);
      @(posedge clk);
      issue_valid <= 1'h1;
      issue <= iss;
      opa <= x;
      opb <= y;
      opd <= z;
      @(posedge clk);
      issue_valid <= 1'h0;
      opa <= ~x;
      opb <= ~y;
      opd <= ~z;
      got_lat = 0;
      do begin
         @(posedge clk);
         got_lat++;
      end while (done !== 1'h1 && got_lat < 20);
      got_data = rd_data;
      got_we = rd_we;
      got_exc = fp_exc;
      got_cause = exception_cause_code;
      check(cfg_err, 1'h0);
   endtask

   task automatic expect_op(input logic [63:0] x, input logic we, input logic exc,
                            input logic [4:0] cause, input int lat);
      check(64'(got_lat), 64'(lat));
      check(got_we, we);
      check(got_exc, exc);
      check(got_cause, cause);
      if (we) check(got_data, x);
   endtask

   function automatic lscd_issue_t mk(lscd_op_t op, logic sd, logic ty, logic ex, logic in,
                                      logic un, logic [5:0] fw, logic [5:0] fs);
      return '{op, sd, ty, ex, in, un, fw, fs};
   endfunction

   // expected shift, extract and insert results
   function automatic logic [63:0] exp_shift(lscd_issue_t q, logic [63:0] x, logic [63:0] z);
      logic [63:0] mask;
      mask = ('1 << q.imm_s) & ('1 >> (63 - q.imm_w));
      if (q.ext) return (x >> q.imm_s) & ~('1 << q.imm_w);
      if (q.ins) return ((x << q.imm_s) & mask) | (z & ~mask);
      if (q.side) return x << q.imm_s;
      if (q.typ) return $signed(x) >>> q.imm_s;
      return x >> q.imm_s;
   endfunction

   // random normal double of moderate magnitude
   function automatic logic [63:0] rnd_dbl();
      return {$random(seed)} % 2 == 0 ? {1'h0, 11'(11'h3F0 + {$random(seed)} % 32),
         20'($random(seed)), 32'($random(seed))} : {1'h1, 11'(11'h3F0 + {$random(seed)} % 32),
         20'($random(seed)), 32'($random(seed))};
   endfunction

   // main sequence
   initial begin
      rst = 1'h1;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      issue_valid = 1'h0;
      issue = '0;
      opa = 64'h0000_0000_0000_0000;
      opb = 64'h0000_0000_0000_0000;
      opd = 64'h0000_0000_0000_0000;
      repeat (4) @(posedge clk);
      rst <= 1'h0;
      // register reset values and an unmapped place
      apb(1'h0, `LSCD_OFS_FPST, 32'h0000_0000);
      check(rdv, `LSCD_FPST_RST);
      apb(1'h0, `LSCD_OFS_EXST, 32'h0000_0000);
      check(rdv, `LSCD_EXST_RST);
      apb(1'h1, 12'h0FC, 32'hFFFF_FFFF);
      check(errv, 1'h1);
      apb(1'h0, 12'h0FC, 32'h0000_0000);
      check(errv, 1'h1);
      check(rdv, 32'h0000_0000);
      apb(1'h0, `LSCD_OFS_CTRL, 32'h0000_0000);
      check(rdv, `LSCD_CTRL_RST);
      // shifts, extract, insert with noise on unused bits
      for (i = 0; i < 60; i++) begin
         m = i % 5;
         a = {$random(seed), $random(seed)};
         d = {$random(seed), $random(seed)};
         s = 6'($random(seed));
         w = 6'($random(seed));
         if (i == 2) s = 6'h00;
         if (i == 7) begin
            s = 6'h3F;
            a[63] = 1'h1;
         end
         if (m == 3) begin
            w = 6'(1 + {$random(seed)} % 63);
            s = 6'({$random(seed)} % (65 - w));
         end
         if (m == 4) w = 6'(s + {$random(seed)} % (64 - s));
         t = mk(op_shift, m == 1 || (m > 2 && $random(seed) % 2 == 0),
            m == 2 || (m > 2 && $random(seed) % 2 == 0), m == 3, m == 4, 1'h0, w, s);
         run_op(t, a, ~a, d);
         expect_op(exp_shift(t, a, d), 1'h1, 1'h0, 5'h00, `LSCD_LAT_SH);
      end
      // long compare, signed and unsigned, with equal and sign corners
      for (i = 0; i < 40; i++) begin
         a = {$random(seed), $random(seed)};
         b = (i < 2) ? a : {$random(seed), $random(seed)};
         if (i == 2 || i == 3) begin
            a = 64'h8000_0000_0000_0000;
            b = 64'h0000_0000_0000_0001;
         end
         e = b + ~a + 64'h0000_0000_0000_0001;
         e[63] = (i % 2 == 1) ? (a > b) : ($signed(a) > $signed(b));
         run_op(mk(op_cmp, 1'h0, 1'h0, 1'h0, 1'h0, i % 2 == 1, 6'h00, 6'h00), a, b, d);
         expect_op(e, 1'h1, 1'h0, 5'h00, `LSCD_LAT_CMP);
      end
      // ordinary double add and reverse subtract
      for (i = 0; i < 40; i++) begin
         a = rnd_dbl();
         b = (i == 5) ? a : rnd_dbl();
         e = (i % 2 == 1) ? $realtobits($bitstoreal(b) - $bitstoreal(a)) :
            $realtobits($bitstoreal(a) + $bitstoreal(b));
         run_op(mk(i % 2 == 1 ? op_drsub : op_dadd, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 6'h00, 6'h00),
            a, b, d);
         expect_op(e, 1'h1, 1'h0, 5'h00, `LSCD_LAT_FP_AREA0);
      end
      // quiet nan passes through without flags
      run_op(mk(op_dadd, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 6'h00, 6'h00), `LSCD_QNAN,
         64'h3FF0_0000_0000_0000, d);
      expect_op(`LSCD_QNAN, 1'h1, 1'h0, 5'h00, `LSCD_LAT_FP_AREA0);
      apb(1'h0, `LSCD_OFS_FPST, 32'h0000_0000);
      check(rdv, 32'h0000_0000);
      // exceptional cases, trapped first and then untrapped
      for (m = 0; m < 2; m++) begin
         for (k = 0; k < 6; k++) begin
            run_op(mk(xo[k], 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 6'h00, 6'h00), xa[k], xb[k], d);
            if (m == 0) expect_op(xr[k], 1'h0, 1'h1, `LSCD_CAUSE_FP, `LSCD_LAT_FP_AREA0);
            else expect_op(xr[k], 1'h1, 1'h0, 5'h00, `LSCD_LAT_FP_AREA0);
            apb(1'h0, `LSCD_OFS_FPST, 32'h0000_0000);
            check(rdv, 32'h0000_0001 << xf[k]);
            apb(1'h1, `LSCD_OFS_FPST, 32'h0000_000F);
            apb(1'h0, `LSCD_OFS_EXST, 32'h0000_0000);
            check(rdv, m == 0 ? 32'h0000_0006 : 32'h0000_0000);
            apb(1'h1, `LSCD_OFS_EXST, 32'h0000_0000);
         end
         apb(1'h1, `LSCD_OFS_CTRL, 32'h0000_0000);
      end
      report_and_stop();
   end

endmodule // tb_top
